/* File: rtl/e1scs_map.svh */
// Register offsets, field positions, reset values and timing figures of the clock select block.
`ifndef E1SCS_MAP_SVH
`define E1SCS_MAP_SVH

`define E1SCS_CTRL_OFFSET     8'h1d
`define E1SCS_CTRL_RESET      8'h00
`define E1SCS_TS_CTRL_OWNER   2'h0

`define E1SCS_BIT_AJACK       7
`define E1SCS_BIT_BACKUP_CLOCK_SELECT        6
`define E1SCS_BIT_SOE         5
`define E1SCS_CSS_HI          4
`define E1SCS_CSS_LO          3
`define E1SCS_SCS_HI          2
`define E1SCS_SCS_LO          0

`define E1SCS_SCS_NONE        3'h0
`define E1SCS_SCS_LAST_PORT   3'h4

`define E1SCS_CLK_KHZ         250000
`define E1SCS_LOSS_NS         2000
`define E1SCS_LOSS_CYCLES     ((`E1SCS_LOSS_NS * `E1SCS_CLK_KHZ + 999999) / 1000000)

`define E1SCS_SYN_KHZ_0       2048
`define E1SCS_SYN_KHZ_1       4096
`define E1SCS_SYN_KHZ_2       8192
`define E1SCS_SYN_KHZ_3       16384

`endif

/* File: rtl/e1scs_pkg.sv */
// Types shared by the clock select block.
package e1scs_pkg;

  typedef struct packed {
    logic       ajack_en;
    logic       backup_sel;
    logic       synth_oe;
    logic [1:0] synth_freq;
    logic [2:0] master_sel;
  } e1scs_ctrl_t;

  typedef struct packed {
    logic tx_clk;
    logic rx_clk;
    logic rx_carrier_loss;
    logic force_backup;
    logic backup_recovered;
  } e1scs_port_in_t;

  typedef struct packed {
    logic tx_clk;
    logic on_backup;
    logic loss_event;
  } e1scs_port_out_t;

  typedef enum logic [2:0] {
    E1SCS_M_NONE   = 3'h1,
    E1SCS_M_LOCAL  = 3'h2,
    E1SCS_M_BACKUP = 3'h4
  } e1scs_master_t;

endpackage

/* File: rtl/e1scs_clock_select.sv */
// Shared system clock interface and per-port transmit clock selection.
//
// How it works
// (RULE_01) One clock interface serves four transceivers; any receiver may be master.
// (RULE_02) Bits 2..0 pick master: 000 none, 001..100 ports 1..4, rest reserved.
// (RULE_03) Reference pin drives out on the master device; elsewhere host writes zeros.
// (RULE_04) Reference feeds synthesizer; bits 4..3 pick 2.048/4.096/8.192/16.384 MHz.
// (RULE_05) Carrier loss on the master port moves the reference to the backup master pin.
// (RULE_06) Control register at 1D exists only when both transceiver select bits are zero.
// (RULE_07) Bit 6 picks the automatic target on transmit clock loss: backup pin or reference.
// (RULE_08) Bit 5 high-impedances the synthesized clock pin when 0, drives it when 1.
// (RULE_09) Bit 7 enables the alternate jitter attenuator.
// (RULE_10) Without interleaved mode the transmit clock comes from the transmit clock pin.
// (RULE_11) Loss of the transmit clock pin switches that port to its assigned backup.
// (RULE_12) Transmit clock loss is reported to the host as an interrupt event.
// (RULE_13) Host may force backup at any time without interleaved mode.
// (RULE_14) Interleaved mode ignores the pin and divides the system clock by 2, 4 or 8.
// (RULE_15) Interleaved mode needs the transmit clock synchronous to the system clock.
// (RULE_16) In interleaved mode, system clock loss switches to the assigned backup.
// (RULE_17) Host may force backup at any time in interleaved mode.
// (RULE_18) The synthesized clock serves interleaved mode for up to eight lines.
// (RULE_19) Reserved master codes behave like 000: reference pin stays an input.
//
// All clock pins are sampled as synchronous levels; clocks here are data-rate waveforms.
`include "e1scs_map.svh"

module e1scs_clock_select (
  // Clock and reset
  input  wire logic                         core_clk,
  input  wire logic                         resetn,
  // Host register port
  input  wire logic [1:0]                   transceiver_select,
  input  wire logic [7:0]                   reg_addr,
  input  wire logic [7:0]                   reg_wdata,
  input  wire logic                         reg_wr,
  output logic      [7:0]                   reg_rdata_q,
  // Per-port clocks and controls
  input  wire e1scs_pkg::e1scs_port_in_t [3:0] port_in,
  output e1scs_pkg::e1scs_port_out_t     [3:0] port_out_q,
  // Interleaved bus mode
  input  wire logic                         interleaved_bus_mode,
  input  wire logic [1:0]                   ibo_div_sel,
  input  wire logic                         system_clock_pin,
  // Reference and backup clocks
  input  wire logic                         backup_master_clock_pin,
  input  wire logic                         shared_reference_pin_in,
  output logic                              shared_reference_pin_out_q,
  output logic                              shared_reference_pin_oe_n_q,
  // Synthesizer and status
  output logic                              synth_clock_output_pin_q,
  output logic                              synth_clock_output_pin_oe_n_q,
  output logic                              alt_jitter_atten_enable_q,
  output logic                              master_on_backup_q
);

  localparam logic [9:0] LossCycles = 10'(`E1SCS_LOSS_CYCLES);

  // Phase increment of the synthesizer accumulator for a frequency in kHz.
  function automatic logic [31:0] e1scs_incr(input int unsigned khz);
    logic [63:0] wide;
    wide = (64'(khz) << 32) / 64'(`E1SCS_CLK_KHZ);
    return wide[31:0];
  endfunction

  // Activity watchdog step: restart on a rising edge, otherwise count up to the limit.
  function automatic logic [9:0] e1scs_watch(input logic [9:0] cnt, input logic now_v,
                                             input logic prev_v);
    logic [9:0] nxt;
    nxt = cnt;
    if (now_v && !prev_v) begin
      nxt = 10'h000;
    end else if (cnt != LossCycles) begin
      nxt = cnt + 10'h001;
    end
    return nxt;
  endfunction

  e1scs_pkg::e1scs_ctrl_t    ctrl_q;
  e1scs_pkg::e1scs_master_t  mst_q;
  e1scs_pkg::e1scs_master_t  mst_d;
  logic                      ctrl_hit;
  logic                      sel_valid;
  logic [1:0]                sel_port;
  logic                      ref_clk;
  logic [31:0]               syn_acc_q;
  logic [31:0]               syn_incr;
  logic                      ref_prev_q;
  logic [9:0]                ref_cnt_q;
  logic                      sys_prev_q;
  logic [9:0]                sys_cnt_q;
  logic                      sys_lost;
  logic [2:0]                sys_div_q;
  logic                      ibo_clk;
  logic [3:0]                tx_prev_q;
  logic [9:0]                tx_cnt_q [4];
  logic [3:0]                src_lost;
  logic [3:0]                src_lost_q;
  logic [3:0]                use_backup;

  // The register answers only in transceiver 1; other transceivers see nothing here.
  assign ctrl_hit  = (transceiver_select == `E1SCS_TS_CTRL_OWNER) &&
                     (reg_addr == `E1SCS_CTRL_OFFSET); // [RULE_06]
  assign sel_valid = (ctrl_q.master_sel != `E1SCS_SCS_NONE) &&
                     (ctrl_q.master_sel <= `E1SCS_SCS_LAST_PORT); // [RULE_02] [RULE_19]
  assign sel_port  = 2'(ctrl_q.master_sel - 3'h1);

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      ctrl_q <= e1scs_pkg::e1scs_ctrl_t'(`E1SCS_CTRL_RESET);
    end else if (reg_wr && ctrl_hit) begin
      ctrl_q <= e1scs_pkg::e1scs_ctrl_t'(reg_wdata); // [RULE_06]
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      reg_rdata_q <= 8'h00;
    end else begin
      reg_rdata_q <= ctrl_hit ? 8'(ctrl_q) : 8'h00; // [RULE_06]
    end
  end

  // Master reference state. A fallback is held until the host writes the select field,
  // so a flapping carrier cannot bounce the system reference back and forth.
  always_comb begin
    mst_d = mst_q;
    case (mst_q)
      e1scs_pkg::E1SCS_M_NONE: begin
        if (sel_valid) begin
          mst_d = e1scs_pkg::E1SCS_M_LOCAL;
        end
      end
      e1scs_pkg::E1SCS_M_LOCAL: begin
        if (!sel_valid) begin
          mst_d = e1scs_pkg::E1SCS_M_NONE;
        end else if (port_in[sel_port].rx_carrier_loss) begin
          mst_d = e1scs_pkg::E1SCS_M_BACKUP; // [RULE_05]
        end
      end
      e1scs_pkg::E1SCS_M_BACKUP: begin
        // Loss wins over a select write that arrives in the same cycle.
        if (sel_valid && port_in[sel_port].rx_carrier_loss) begin
          mst_d = e1scs_pkg::E1SCS_M_BACKUP; // [RULE_05]
        end else if (reg_wr && ctrl_hit) begin
          mst_d = e1scs_pkg::E1SCS_M_NONE;
        end
      end
      default: begin
        mst_d = e1scs_pkg::E1SCS_M_NONE;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      mst_q <= e1scs_pkg::E1SCS_M_NONE;
    end else begin
      mst_q <= mst_d;
    end
  end

  // Reference pin: driven on the sourcing device, an input on all others.
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      shared_reference_pin_out_q  <= 1'b0;
      shared_reference_pin_oe_n_q <= 1'b1;
      master_on_backup_q          <= 1'b0;
    end else begin
      shared_reference_pin_oe_n_q <= !sel_valid; // [RULE_03] [RULE_19]
      shared_reference_pin_out_q  <= (mst_q == e1scs_pkg::E1SCS_M_BACKUP) ?
                                     backup_master_clock_pin :
                                     (sel_valid && port_in[sel_port].rx_clk); // [RULE_01]
      master_on_backup_q          <= (mst_q == e1scs_pkg::E1SCS_M_BACKUP); // [RULE_05]
    end
  end

  // On a sourcing device the reference is our own driven value; otherwise the pin.
  assign ref_clk = sel_valid ? shared_reference_pin_out_q : shared_reference_pin_in;

  // The synthesizer is a phase accumulator; its edges carry the jitter of one core cycle,
  // which is the price of reaching 16.384 MHz from a 250 MHz clock without a PLL.
  always_comb begin
    case (ctrl_q.synth_freq)
      2'h0:    syn_incr = e1scs_incr(`E1SCS_SYN_KHZ_0); // [RULE_04]
      2'h1:    syn_incr = e1scs_incr(`E1SCS_SYN_KHZ_1);
      2'h2:    syn_incr = e1scs_incr(`E1SCS_SYN_KHZ_2);
      2'h3:    syn_incr = e1scs_incr(`E1SCS_SYN_KHZ_3);
      default: syn_incr = e1scs_incr(`E1SCS_SYN_KHZ_0);
    endcase
  end

  // Reference activity watchdog. Gating the accumulator on the reference level would
  // stretch the low phase and pull every rate down, so only activity is tested here.
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      ref_prev_q <= 1'b0;
      ref_cnt_q  <= 10'h000;
    end else begin
      ref_prev_q <= ref_clk;
      ref_cnt_q  <= e1scs_watch(ref_cnt_q, ref_clk, ref_prev_q); // [RULE_04]
    end
  end

  // The synthesizer runs while edges arrive on its reference and stops once it is quiet.
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      syn_acc_q <= 32'h0000_0000;
    end else if (ref_cnt_q != LossCycles) begin
      syn_acc_q <= syn_acc_q + syn_incr; // [RULE_04] [RULE_18]
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      synth_clock_output_pin_q      <= 1'b0;
      synth_clock_output_pin_oe_n_q <= 1'b1;
      alt_jitter_atten_enable_q     <= 1'b0;
    end else begin
      synth_clock_output_pin_q      <= syn_acc_q[31];
      synth_clock_output_pin_oe_n_q <= !ctrl_q.synth_oe; // [RULE_08]
      alt_jitter_atten_enable_q     <= ctrl_q.ajack_en; // [RULE_09]
    end
  end

  // System clock watchdog and interleaved divider, shared by all four ports.
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      sys_prev_q <= 1'b0;
      sys_cnt_q  <= 10'h000;
      sys_div_q  <= 3'h0;
    end else begin
      sys_prev_q <= system_clock_pin;
      sys_cnt_q  <= e1scs_watch(sys_cnt_q, system_clock_pin, sys_prev_q); // [RULE_16]
      if (system_clock_pin && !sys_prev_q) begin
        sys_div_q <= sys_div_q + 3'h1; // [RULE_14] [RULE_15]
      end
    end
  end

  assign sys_lost = (sys_cnt_q == LossCycles);

  always_comb begin
    case (ibo_div_sel)
      2'h0:    ibo_clk = sys_div_q[0]; // [RULE_14]
      2'h1:    ibo_clk = sys_div_q[1];
      default: ibo_clk = sys_div_q[2];
    endcase
  end

  // Transmit clock pin watchdogs, one per port.
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      tx_prev_q <= 4'h0;
      for (int i = 0; i < 4; i++) begin
        tx_cnt_q[i] <= 10'h000;
      end
    end else begin
      for (int i = 0; i < 4; i++) begin
        tx_prev_q[i] <= port_in[i].tx_clk;
        tx_cnt_q[i]  <= e1scs_watch(tx_cnt_q[i], port_in[i].tx_clk, tx_prev_q[i]); // [RULE_11]
      end
    end
  end

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      src_lost[i]   = interleaved_bus_mode ? sys_lost :
                      (tx_cnt_q[i] == LossCycles); // [RULE_11] [RULE_16]
      use_backup[i] = src_lost[i] || port_in[i].force_backup; // [RULE_13] [RULE_17]
    end
  end

  // Per-port transmit clock mux and loss event.
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      port_out_q <= '0;
      src_lost_q <= 4'h0;
    end else begin
      src_lost_q <= src_lost;
      for (int i = 0; i < 4; i++) begin
        port_out_q[i].on_backup  <= use_backup[i];
        port_out_q[i].loss_event <= src_lost[i] && !src_lost_q[i]; // [RULE_12]
        if (!use_backup[i]) begin
          port_out_q[i].tx_clk <= interleaved_bus_mode ? ibo_clk :
                                  port_in[i].tx_clk; // [RULE_10] [RULE_14]
        end else if (port_in[i].backup_recovered) begin
          port_out_q[i].tx_clk <= port_in[i].rx_clk; // [RULE_11]
        end else begin
          port_out_q[i].tx_clk <= ctrl_q.backup_sel ? ref_clk :
                                  backup_master_clock_pin; // [RULE_07]
        end
      end
    end
  end

  // Checks.
  chk_reg_owner_only: assert property (@(posedge core_clk) disable iff (!resetn) // [RULE_06]
    (reg_wr && transceiver_select != `E1SCS_TS_CTRL_OWNER) |=> $stable(ctrl_q))
    else $error("Control register changed from a non-owner transceiver.");

  chk_reg_write_read: assert property (@(posedge core_clk) disable iff (!resetn) // [RULE_06]
    (reg_wr && ctrl_hit) ##1 (ctrl_hit && !reg_wr) |=> (reg_rdata_q == $past(reg_wdata, 2)))
    else $error("Control register readback differs from written value.");

  chk_ref_pin_input: assert property (@(posedge core_clk) disable iff (!resetn) // [RULE_19]
    (ctrl_q.master_sel == `E1SCS_SCS_NONE || ctrl_q.master_sel > `E1SCS_SCS_LAST_PORT)
    |=> shared_reference_pin_oe_n_q)
    else $error("Reference pin driven without a local master.");

  chk_ref_pin_drive: assert property (@(posedge core_clk) disable iff (!resetn) // [RULE_03]
    (ctrl_q.master_sel inside {3'h1, 3'h2, 3'h3, 3'h4}) [*2] |-> !shared_reference_pin_oe_n_q)
    else $error("Reference pin not driven on the master device.");

  chk_master_fallback: assert property (@(posedge core_clk) disable iff (!resetn) // [RULE_05]
    (mst_q == e1scs_pkg::E1SCS_M_LOCAL && sel_valid && port_in[sel_port].rx_carrier_loss)
    |=> ##1 master_on_backup_q)
    else $error("Master carrier loss did not move reference to backup pin.");

  chk_synth_oe: assert property (@(posedge core_clk) disable iff (!resetn) // [RULE_08]
    $rose(ctrl_q.synth_oe) |=> !synth_clock_output_pin_oe_n_q)
    else $error("Synthesizer pin not driven after enable.");

  chk_jitter_bit: assert property (@(posedge core_clk) disable iff (!resetn) // [RULE_09]
    $changed(ctrl_q.ajack_en) |=> (alt_jitter_atten_enable_q == $past(ctrl_q.ajack_en)))
    else $error("Jitter attenuator enable does not follow bit 7.");

  chk_tx_pin_path: assert property (@(posedge core_clk) disable iff (!resetn) // [RULE_10]
    (!interleaved_bus_mode && !use_backup[0])
    |=> (port_out_q[0].tx_clk == $past(port_in[0].tx_clk)))
    else $error("Port 1 transmit clock not taken from its pin.");

  chk_tx_loss_backup: assert property (@(posedge core_clk) disable iff (!resetn) // [RULE_11]
    (!interleaved_bus_mode && tx_cnt_q[0] == LossCycles) |=> port_out_q[0].on_backup)
    else $error("Port 1 did not switch to backup on clock loss.");

  chk_loss_event: assert property (@(posedge core_clk) disable iff (!resetn) // [RULE_12]
    $rose(src_lost[2]) |=> port_out_q[2].loss_event ##1 !port_out_q[2].loss_event)
    else $error("Loss event is not a single pulse.");

  chk_force_backup: assert property (@(posedge core_clk) disable iff (!resetn) // [RULE_13]
    port_in[3].force_backup |=> port_out_q[3].on_backup)
    else $error("Forced backup ignored on port 4.");

  chk_ibo_divide: assert property (@(posedge core_clk) disable iff (!resetn) // [RULE_14]
    (system_clock_pin && !sys_prev_q) |=> (sys_div_q == $past(sys_div_q) + 3'h1))
    else $error("Interleaved divider missed a system clock edge.");

  chk_sys_loss: assert property (@(posedge core_clk) disable iff (!resetn) // [RULE_16]
    (interleaved_bus_mode && sys_lost) |=> (port_out_q[0].on_backup && port_out_q[3].on_backup))
    else $error("System clock loss did not switch ports to backup.");

  chk_backup_target: assert property (@(posedge core_clk) disable iff (!resetn) // [RULE_07]
    (use_backup[0] && !port_in[0].backup_recovered && !ctrl_q.backup_sel)
    |=> (port_out_q[0].tx_clk == $past(backup_master_clock_pin)))
    else $error("Backup target does not follow bit 6.");

endmodule

/* File: test/e1scs_far_clocks.sv */
// Clock sources and the neighbouring device that surround the clock select block.
module e1scs_far_clocks (
  // Clock
  input  wire logic       core_clk,
  // Source stop controls from the bench
  input  wire logic [3:0] stop_tx,
  input  wire logic       stop_sys,
  // Generated clock waveforms
  output logic      [3:0] tx_clk,
  output logic      [3:0] rx_clk,
  output logic            system_clock_pin,
  output logic            backup_master_clock_pin,
  // Shared reference wire
  input  wire logic       ref_out,
  input  wire logic       ref_oe_n,
  output logic            ref_wire
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [7:0] cnt_q = 8'h00;

  always_ff @(posedge core_clk) begin
    cnt_q <= cnt_q + 8'h01;
  end

  // Transmit pins run slowly but steadily; a stopped pin parks low, as a dead source would.
  assign tx_clk = {4{cnt_q[6]}} & ~stop_tx;
  // One counter feeds transmit and system clocks, so they can never slip.
  assign system_clock_pin = cnt_q[1] & ~stop_sys;
  // Each port recovers a different rate, so a wrong port choice shows up in edge counts.
  assign rx_clk = {cnt_q[4], cnt_q[3], cnt_q[2], cnt_q[1]};
  assign backup_master_clock_pin = cnt_q[2] & cnt_q[1];
  // The neighbour drives the reference only while this device leaves the pin as input.
  assign ref_wire = ref_oe_n ? (cnt_q[3] & cnt_q[2]) : ref_out;
endmodule

/* File: test/e1scs_clock_select_test.sv */
// Self-checking bench for the clock select block.
`include "e1scs_map.svh"
module e1scs_clock_select_test;
  timeunit 1ns;
  timeprecision 1ps;

  logic                              core_clk = 1'b0;
  logic                              resetn = 1'b0;
  logic [1:0]                        transceiver_select = 2'h0;
  logic [7:0]                        reg_addr = 8'h00;
  logic [7:0]                        reg_wdata = 8'h00;
  logic                              reg_wr = 1'b0;
  logic [7:0]                        reg_rdata_q;
  e1scs_pkg::e1scs_port_in_t  [3:0]  port_in;
  e1scs_pkg::e1scs_port_out_t [3:0]  port_out_q;
  logic                              interleaved_bus_mode = 1'b0;
  logic [1:0]                        ibo_div_sel = 2'h0;
  logic                              system_clock_pin;
  logic                              backup_master_clock_pin;
  logic                              ref_wire;
  logic                              ref_out_q;
  logic                              ref_oe_n_q;
  logic                              synth_q;
  logic                              synth_oe_n_q;
  logic                              ajack_q;
  logic                              master_on_backup_q;
  logic [3:0]                        tx_clk;
  logic [3:0]                        rx_clk;
  logic [3:0]                        stop_tx = 4'h0;
  logic                              stop_sys = 1'b0;
  logic [3:0]                        carrier_loss = 4'h0;
  logic [3:0]                        force_bk = 4'h0;
  logic [3:0]                        bk_rec = 4'h0;
  int                                n_errors = 0;
  int                                compares = 0;
  int                                cycles = 0;
  int                                n;
  logic [7:0]                        rd;

  initial begin
    forever #2 core_clk = ~core_clk;
  end

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      port_in[i] = {tx_clk[i], rx_clk[i], carrier_loss[i], force_bk[i], bk_rec[i]};
    end
  end

  e1scs_far_clocks far (.core_clk(core_clk), .stop_tx(stop_tx), .stop_sys(stop_sys),
    .tx_clk(tx_clk), .rx_clk(rx_clk), .system_clock_pin(system_clock_pin),
    .backup_master_clock_pin(backup_master_clock_pin), .ref_out(ref_out_q),
    .ref_oe_n(ref_oe_n_q), .ref_wire(ref_wire));

  e1scs_clock_select dut (.core_clk(core_clk), .resetn(resetn),
    .transceiver_select(transceiver_select), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rdata_q(reg_rdata_q), .port_in(port_in), .port_out_q(port_out_q),
    .interleaved_bus_mode(interleaved_bus_mode), .ibo_div_sel(ibo_div_sel),
    .system_clock_pin(system_clock_pin), .backup_master_clock_pin(backup_master_clock_pin),
    .shared_reference_pin_in(ref_wire), .shared_reference_pin_out_q(ref_out_q),
    .shared_reference_pin_oe_n_q(ref_oe_n_q), .synth_clock_output_pin_q(synth_q),
    .synth_clock_output_pin_oe_n_q(synth_oe_n_q), .alt_jitter_atten_enable_q(ajack_q),
    .master_on_backup_q(master_on_backup_q));

  task automatic print_verdict();
    $display("compares %0d n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // The ceiling sits well above the longest path through the tests.
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 60000) begin
      n_errors++;
      print_verdict();
    end
  end

  task automatic check_val(input string what, input logic [7:0] exp, input logic [7:0] seen);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic check_range(input string what, input int lo, input int hi, input int seen);
    compares++;
    if (seen < lo || seen > hi) begin
      n_errors++;
      $display("wrong value %s expected %0d..%0d seen %0d", what, lo, hi, seen);
    end
  endtask

  task automatic reg_write(input logic [1:0] ts, input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    transceiver_select <= ts;
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic reg_read(input logic [1:0] ts, input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk);
    transceiver_select <= ts;
    reg_addr <= a;
    repeat (2) @(posedge core_clk);
    #1 d = reg_rdata_q;
  endtask

  task automatic settle(input int c);
    repeat (c) @(posedge core_clk);
    #1;
  endtask

  function automatic logic pick(input int w);
    case (w)
      0: return ref_out_q;
      1: return synth_q;
      default: return port_out_q[w-2].tx_clk;
    endcase
  endfunction

  // Counts rising edges of one output; the first sample never counts as an edge.
  task automatic count_edges(input int w, input int c, output int cnt);
    logic prev;
    logic cur;
    cnt = 0;
    prev = 1'b1;
    repeat (c) begin
      @(posedge core_clk);
      #1 cur = pick(w);
      if (cur === 1'b1 && prev === 1'b0) cnt++;
      prev = cur;
    end
  endtask

  task automatic wait_loss(input int p);
    for (int i = 0; i < 600; i++) begin
      @(posedge core_clk);
      #1;
      if (port_out_q[p].loss_event === 1'b1) break;
    end
    check_val("loss_event", 8'h01, {7'h00, port_out_q[p].loss_event});
    check_val("on_backup", 8'h01, {7'h00, port_out_q[p].on_backup});
    settle(1);
    check_val("loss_event", 8'h00, {7'h00, port_out_q[p].loss_event});
  endtask

  initial begin
    settle(16);
    resetn <= 1'b1;
    settle(1);
    check_val("ref_oe_n", 8'h01, {7'h00, ref_oe_n_q});
    check_val("synth_oe_n", 8'h01, {7'h00, synth_oe_n_q});
    reg_write(2'h1, `E1SCS_CTRL_OFFSET, 8'hff);
    reg_read(2'h0, `E1SCS_CTRL_OFFSET, rd);
    check_val("ctrl", 8'h00, rd);
    reg_read(2'h1, `E1SCS_CTRL_OFFSET, rd);
    check_val("ctrl other", 8'h00, rd);
    reg_write(2'h0, `E1SCS_CTRL_OFFSET, 8'ha0);
    reg_read(2'h0, 8'h1c, rd);
    check_val("unmapped", 8'h00, rd);
    reg_read(2'h0, `E1SCS_CTRL_OFFSET, rd);
    check_val("ctrl", 8'ha0, rd);
    check_val("ajack", 8'h01, {7'h00, ajack_q});
    check_val("synth_oe_n", 8'h00, {7'h00, synth_oe_n_q});
    // Every master code, reserved ones included; local ports differ in edge rate.
    for (int s = 0; s < 8; s++) begin
      reg_write(2'h0, `E1SCS_CTRL_OFFSET, 8'(s));
      settle(3);
      check_val("ref_oe_n", (s >= 1 && s <= 4) ? 8'h00 : 8'h01, {7'h00, ref_oe_n_q});
      if (s >= 1 && s <= 4) begin
        count_edges(0, 64, n);
        check_range("ref edges", (16 >> (s - 1)) - 1, (16 >> (s - 1)) + 1, n);
      end
    end
    check_val("synth_oe_n", 8'h01, {7'h00, synth_oe_n_q});
    reg_write(2'h0, `E1SCS_CTRL_OFFSET, 8'h01);
    settle(3);
    carrier_loss[0] <= 1'b1;
    settle(3);
    check_val("master_on_backup", 8'h01, {7'h00, master_on_backup_q});
    count_edges(0, 64, n);
    check_range("ref edges backup", 7, 9, n);
    carrier_loss[0] <= 1'b0;
    reg_write(2'h0, `E1SCS_CTRL_OFFSET, 8'h01);
    settle(3);
    check_val("master_on_backup", 8'h00, {7'h00, master_on_backup_q});
    // Synthesizer rates are averages, so a loose window is allowed.
    for (int f = 0; f < 4; f++) begin
      reg_write(2'h0, `E1SCS_CTRL_OFFSET, 8'h21 | 8'(f << 3));
      settle(20);
      count_edges(1, 2000, n);
      check_range("synth edges", (16 << f) * 3 / 4 - 2, (17 << f) * 5 / 4 + 2, n);
    end
    reg_write(2'h0, `E1SCS_CTRL_OFFSET, 8'h00);
    count_edges(2, 256, n);
    check_range("tx edges pin", 1, 3, n);
    stop_tx[0] <= 1'b1;
    wait_loss(0);
    count_edges(2, 64, n);
    check_range("tx edges backup pin", 7, 9, n);
    bk_rec[0] <= 1'b1;
    settle(3);
    count_edges(2, 64, n);
    check_range("tx edges recovered", 15, 17, n);
    bk_rec[0] <= 1'b0;
    reg_write(2'h0, `E1SCS_CTRL_OFFSET, 8'h40);
    settle(3);
    count_edges(2, 64, n);
    check_range("tx edges reference", 3, 5, n);
    force_bk[1] <= 1'b1;
    settle(3);
    check_val("forced on_backup", 8'h01, {7'h00, port_out_q[1].on_backup});
    force_bk[1] <= 1'b0;
    stop_tx <= 4'h0;
    interleaved_bus_mode <= 1'b1;
    settle(3);
    stop_tx <= 4'hf;
    for (int d = 0; d < 3; d++) begin
      ibo_div_sel <= 2'(d);
      settle(8);
      count_edges(4, 128, n);
      check_range("ibo tx edges", (16 >> d) - 1, (16 >> d) + 1, n);
    end
    check_val("ibo on_backup", 8'h00, {7'h00, port_out_q[2].on_backup});
    force_bk[3] <= 1'b1;
    settle(3);
    check_val("ibo forced", 8'h01, {7'h00, port_out_q[3].on_backup});
    stop_sys <= 1'b1;
    wait_loss(0);
    print_verdict();
  end
endmodule
